// [hw/catl_core.v]
// execution core for subtract, trap, transfers, test and low-power halt
// Behaviour
// - subtract and test set negative from result bit 7, else clear it.
// - subtract carry set when operand plus old carry exceeds accumulator.
// - subtract literal a0 takes 2 cycles, full address c0 takes 4.
// - subtract indexed f0 3 cycles, e0 4 cycles, d0 5 cycles.
// - trap advances pc by one, then stacks pc, index, accumulator.
// - pc low byte pushed before high; stack pointer drops after each byte.
// - flag register pushed last, flags in bits 4-0, ones above.
// - after trap stacking the interrupt mask flag is set.
// - trap loads pc high from xffc and pc low from xffd.
// - trap opcode 83 takes 10 cycles, ignoring the interrupt mask.
// - opcode 97 copies accumulator into index; flags unchanged; 2 cycles.
// - opcode 9f copies index into accumulator; flags unchanged; 2 cycles.
// - test sets negative from bit 7, zero on 00; others untouched.
// - test opcodes 4d, 5d 3 cycles; 3d, 7d 4; 6d 5; operand unchanged.
// - halt opcode 8f clears mask and stops processor clocking; 2 cycles.
// - timer and peripherals stay clocked while halted.
// - reset, external pin low or unit request wake the processor.
// - maskable interrupts are not serviced while the mask is set.
`timescale 1ns/1ps
`default_nettype none
`include "catl_consts.vh"
module catl_core #(
    parameter [3:0] VEC_PAGE = 4'h1
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // axi4-lite write address and data
    input wire [4:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    // axi4-lite read
    input wire [4:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // wake sources
    input wire ext_irq_n_in,
    input wire unit_req_in,
    // cpu bus for stacking and vector fetch
    output reg [15:0] mem_addr_out,
    output reg [7:0] mem_wdata_out,
    output reg mem_we_out,
    output reg mem_re_out,
    input wire [7:0] mem_rdata_in,
    // clock gating
    output reg cpu_clk_en_out,
    output wire periph_clk_en_out
);
    // one-hot states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_EXEC = 4'b0010;
    localparam [3:0] ST_HALT = 4'b0100;
    localparam [3:0] ST_SVC = 4'b1000;

    reg [3:0] state;
    reg [7:0] acc;
    reg [7:0] idx;
    reg [7:0] flags;
    reg [15:0] pc;
    reg [7:0] sp;
    reg [7:0] opcode;
    reg [7:0] operand;
    reg [3:0] cyc_left;
    reg [3:0] step;
    reg [11:0] vec_lo;
    reg bad_op;
    reg [3:0] next_cycles;
    reg next_valid;
    // axi holding
    reg aw_held;
    reg w_held;
    reg [4:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire wr_go;
    wire start;
    wire [8:0] diff;
    wire [7:0] tst_val;

    // opcode decode to cycle count
    always @*
    begin
        next_valid = 1'b1;
        case (w_data[7:0])
            // subtract literal and full address
            `CATL_OP_SUB_LIT: next_cycles = `CATL_CYC_SUB_LIT;
            `CATL_OP_SUB_FULL: next_cycles = `CATL_CYC_SUB_FULL;
            // subtract indexed forms
            `CATL_OP_SUB_IX0: next_cycles = `CATL_CYC_SUB_IX0;
            `CATL_OP_SUB_IX1: next_cycles = `CATL_CYC_SUB_IX1;
            `CATL_OP_SUB_IX2: next_cycles = `CATL_CYC_SUB_IX2;
            // trap length
            `CATL_OP_TRAP: next_cycles = `CATL_CYC_TRAP;
            `CATL_OP_TAX: next_cycles = `CATL_CYC_XFER;
            `CATL_OP_TXA: next_cycles = `CATL_CYC_XFER;
            // test forms
            `CATL_OP_TST_A: next_cycles = `CATL_CYC_TST_REG;
            `CATL_OP_TST_X: next_cycles = `CATL_CYC_TST_REG;
            `CATL_OP_TST_PZ: next_cycles = `CATL_CYC_TST_PZ;
            `CATL_OP_TST_IX0: next_cycles = `CATL_CYC_TST_IX0;
            `CATL_OP_TST_IX1: next_cycles = `CATL_CYC_TST_IX1;
            `CATL_OP_HALT: next_cycles = `CATL_CYC_HALT;
            default:
            begin
                next_cycles = 4'd1;
                next_valid = 1'b0;
            end
        endcase
    end

    // axi handshakes
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
    assign start = wr_go && (aw_addr == `CATL_REG_CTRL) && w_strb[0] && (state == ST_IDLE);
    // peripherals never gated
    // peripherals stay clocked
    assign periph_clk_en_out = 1'b1;
    // subtract with borrow out in bit 8
    assign diff = {1'b0, acc} - {1'b0, operand} - {8'h00, flags[`CATL_F_C]};
    assign tst_val = (opcode == `CATL_OP_TST_A) ? acc :
                     (opcode == `CATL_OP_TST_X) ? idx : operand;

    // axi write address/data capture and response
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `CATL_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                // only ctrl and operand are writable; busy core refuses ctrl
                if ((aw_addr == `CATL_REG_OPER) ||
                    ((aw_addr == `CATL_REG_CTRL) && (state == ST_IDLE)))
                    s_axi_bresp_out <= `CATL_RESP_OKAY;
                else
                    s_axi_bresp_out <= `CATL_RESP_SLVERR;
            end
            else if (s_axi_bvalid_out && s_axi_bready_in)
                s_axi_bvalid_out <= 1'b0;
        end
    end

    // axi read
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `CATL_RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= `CATL_RESP_OKAY;
            case (s_axi_araddr_in)
                `CATL_REG_CTRL: s_axi_rdata_out <= {24'h000000, opcode};
                `CATL_REG_OPER: s_axi_rdata_out <= {24'h000000, operand};
                `CATL_REG_ACC: s_axi_rdata_out <= {24'h000000, acc};
                `CATL_REG_IDX: s_axi_rdata_out <= {24'h000000, idx};
                `CATL_REG_FLAG: s_axi_rdata_out <= {24'h000000, flags};
                `CATL_REG_STAT: s_axi_rdata_out <= {27'h0000000, bad_op, state};
                `CATL_REG_PC: s_axi_rdata_out <= {16'h0000, pc};
                `CATL_REG_SP: s_axi_rdata_out <= {24'h000000, sp};
                default:
                begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= `CATL_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid_out && s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
    end

    // execution sequencer
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            acc <= 8'h00;
            idx <= 8'h00;
            flags <= {`CATL_FLAG_TOP, 5'b01000};
            pc <= 16'h0000;
            sp <= `CATL_SP_RESET;
            opcode <= 8'h00;
            operand <= 8'h00;
            cyc_left <= 4'd0;
            step <= 4'd0;
            vec_lo <= `CATL_VEC_TRAP_LO;
            bad_op <= 1'b0;
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 8'h00;
            mem_we_out <= 1'b0;
            mem_re_out <= 1'b0;
            cpu_clk_en_out <= 1'b1;
        end
        else
        begin
            mem_we_out <= 1'b0;
            mem_re_out <= 1'b0;
            if (wr_go && (aw_addr == `CATL_REG_OPER) && w_strb[0])
                operand <= w_data[7:0];
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        opcode <= w_data[7:0];
                        bad_op <= !next_valid;
                        cyc_left <= next_cycles;
                        step <= 4'd0;
                        vec_lo <= `CATL_VEC_TRAP_LO;
                        state <= next_valid ? ST_EXEC : ST_IDLE;
                    end
                end
                ST_EXEC:
                begin
                    step <= step + 4'd1;
                    if (opcode == `CATL_OP_TRAP)
                    begin
                        case (step)
                            4'd0: pc <= pc + 16'h0001;
                            4'd1:
                            begin
                                mem_addr_out <= {8'h00, sp};
                                mem_wdata_out <= pc[7:0];
                                mem_we_out <= 1'b1;
                                sp <= sp - 8'h01;
                            end
                            4'd2:
                            begin
                                mem_addr_out <= {8'h00, sp};
                                mem_wdata_out <= pc[15:8];
                                mem_we_out <= 1'b1;
                                sp <= sp - 8'h01;
                            end
                            4'd3:
                            begin
                                mem_addr_out <= {8'h00, sp};
                                mem_wdata_out <= idx;
                                mem_we_out <= 1'b1;
                                sp <= sp - 8'h01;
                            end
                            4'd4:
                            begin
                                mem_addr_out <= {8'h00, sp};
                                mem_wdata_out <= acc;
                                mem_we_out <= 1'b1;
                                sp <= sp - 8'h01;
                            end
                            4'd5:
                            begin
                                mem_addr_out <= {8'h00, sp};
                                mem_wdata_out <= {`CATL_FLAG_TOP, flags[4:0]};
                                mem_we_out <= 1'b1;
                                sp <= sp - 8'h01;
                            end
                            4'd6:
                            begin
                                flags[`CATL_F_I] <= 1'b1;
                                mem_addr_out <= {VEC_PAGE, vec_lo};
                                mem_re_out <= 1'b1;
                            end
                            4'd7: pc[15:8] <= mem_rdata_in;
                            4'd8:
                            begin
                                mem_addr_out <= {VEC_PAGE, vec_lo + 12'h001};
                                mem_re_out <= 1'b1;
                            end
                            4'd9: pc[7:0] <= mem_rdata_in;
                            default: pc <= pc;
                        endcase
                    end
                    if (cyc_left == 4'd1)
                    begin
                        state <= ST_IDLE;
                        case (opcode)
                            `CATL_OP_TAX: idx <= acc;
                            `CATL_OP_TXA: acc <= idx;
                            `CATL_OP_HALT:
                            begin
                                flags[`CATL_F_I] <= 1'b0;
                                cpu_clk_en_out <= 1'b0;
                                state <= ST_HALT;
                            end
                            `CATL_OP_TST_A, `CATL_OP_TST_X, `CATL_OP_TST_PZ,
                            `CATL_OP_TST_IX0, `CATL_OP_TST_IX1:
                            begin
                                flags[`CATL_F_N] <= tst_val[7];
                                flags[`CATL_F_Z] <= (tst_val == 8'h00);
                            end
                            `CATL_OP_TRAP: acc <= acc;
                            default:
                            begin
                                acc <= diff[7:0];
                                flags[`CATL_F_N] <= diff[7];
                                flags[`CATL_F_Z] <= (diff[7:0] == 8'h00);
                                flags[`CATL_F_C] <= diff[8];
                            end
                        endcase
                    end
                    cyc_left <= cyc_left - 4'd1;
                end
                ST_HALT:
                begin
                    // wake on pin low or unit request
                    if ((!ext_irq_n_in || unit_req_in) && !flags[`CATL_F_I])
                    begin
                        cpu_clk_en_out <= 1'b1;
                        state <= ST_SVC;
                        vec_lo <= !ext_irq_n_in ? `CATL_VEC_IRQ_LO : `CATL_VEC_UNIT_LO;
                    end
                end
                ST_SVC:
                begin
                    // service via trap sequence, own vector
                    opcode <= `CATL_OP_TRAP;
                    cyc_left <= `CATL_CYC_TRAP - 4'd1;
                    step <= 4'd1;
                    state <= ST_EXEC;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [pkg/catl_consts.vh]
// constants for the cpu arithmetic, trap and low-power execution block
`ifndef CATL_CONSTS_VH
`define CATL_CONSTS_VH
// opcodes
`define CATL_OP_SUB_LIT 8'ha0
`define CATL_OP_SUB_FULL 8'hc0
`define CATL_OP_SUB_IX0 8'hf0
`define CATL_OP_SUB_IX1 8'he0
`define CATL_OP_SUB_IX2 8'hd0
`define CATL_OP_TRAP 8'h83
`define CATL_OP_TAX 8'h97
`define CATL_OP_TXA 8'h9f
`define CATL_OP_TST_A 8'h4d
`define CATL_OP_TST_X 8'h5d
`define CATL_OP_TST_PZ 8'h3d
`define CATL_OP_TST_IX0 8'h7d
`define CATL_OP_TST_IX1 8'h6d
`define CATL_OP_HALT 8'h8f
// cycle counts
`define CATL_CYC_SUB_LIT 4'd2
`define CATL_CYC_SUB_FULL 4'd4
`define CATL_CYC_SUB_IX0 4'd3
`define CATL_CYC_SUB_IX1 4'd4
`define CATL_CYC_SUB_IX2 4'd5
`define CATL_CYC_TRAP 4'd10
`define CATL_CYC_XFER 4'd2
`define CATL_CYC_TST_REG 4'd3
`define CATL_CYC_TST_PZ 4'd4
`define CATL_CYC_TST_IX0 4'd4
`define CATL_CYC_TST_IX1 4'd5
`define CATL_CYC_HALT 4'd2
// flag positions inside flag_register
`define CATL_F_H 4
`define CATL_F_I 3
`define CATL_F_N 2
`define CATL_F_Z 1
`define CATL_F_C 0
`define CATL_FLAG_TOP 3'b111
// reset values and vectors (high nibble x chosen by parameter)
`define CATL_SP_RESET 8'hff
`define CATL_VEC_TRAP_LO 12'hffc
`define CATL_VEC_IRQ_LO 12'hffa
`define CATL_VEC_UNIT_LO 12'hff8
// axi-lite register map
`define CATL_REG_CTRL 5'h00
`define CATL_REG_OPER 5'h04
`define CATL_REG_ACC 5'h08
`define CATL_REG_IDX 5'h0c
`define CATL_REG_FLAG 5'h10
`define CATL_REG_STAT 5'h14
`define CATL_REG_PC 5'h18
`define CATL_REG_SP 5'h1c
`define CATL_RESP_OKAY 2'b00
`define CATL_RESP_SLVERR 2'b10
`endif

// [dv/catl_mem_model.sv]
// byte store standing on the cpu bus for stacking and vector fetch
`timescale 1ns/1ps
`default_nettype none
module catl_mem_model (
    // clock
    input wire logic clk_in,
    // cpu bus
    input wire logic [15:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    input wire logic mem_we_in,
    input wire logic mem_re_in,
    output logic [7:0] mem_rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_rd = 8'h5a;
    // data stands while the strobe stands, inverted last read otherwise
    assign mem_rdata_out = mem_re_in ? mem[mem_addr_in] : ~last_rd;
    always @(posedge clk_in)
    begin
        if (mem_we_in)
            mem[mem_addr_in] <= mem_wdata_in;
        if (mem_re_in)
            last_rd <= mem[mem_addr_in];
    end
endmodule
`default_nettype wire

// [dv/catl_core_assertions.sv]
// checker for stacking, vector fetch and clock gating at the core ports
`timescale 1ns/1ps
`default_nettype none
module catl_core_assertions #(
    parameter [3:0] VEC_PAGE = 4'h1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // wake sources
    input wire logic ext_irq_n_in,
    input wire logic unit_req_in,
    // cpu bus and gating
    input wire logic [15:0] mem_addr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic mem_we_out,
    input wire logic mem_re_out,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    periph_clocked_a: assert property (periph_clk_en_out)
        else $error("peripheral clock gated");
    stack_page_a: assert property (mem_we_out |-> mem_addr_out[15:8] == 8'h00)
        else $error("stack write off page zero");
    stack_dec_a: assert property (mem_we_out && $past(mem_we_out) |->
        mem_addr_out == $past(mem_addr_out) - 16'h1) else $error("stack pointer not stepping down");
    five_pushes_a: assert property ($rose(mem_we_out) |-> mem_we_out [*5] ##1 !mem_we_out)
        else $error("context is not five bytes");
    vector_first_a: assert property ($fell(mem_we_out) |-> mem_re_out &&
        mem_addr_out[15:12] == VEC_PAGE && mem_addr_out[11:0] inside {12'hffc, 12'hffa, 12'hff8})
        else $error("vector high byte not fetched");
    vector_second_a: assert property ($fell(mem_we_out) |-> ##2 mem_re_out &&
        mem_addr_out == $past(mem_addr_out, 2) + 16'h1) else $error("vector low byte wrong");
    flags_top_a: assert property ($fell(mem_we_out) |->
        $past(mem_wdata_out[7:5]) == 3'b111) else $error("stacked flags top bits");
    halt_quiet_a: assert property (!cpu_clk_en_out |-> !mem_we_out && !mem_re_out)
        else $error("bus activity while halted");
    wake_up_a: assert property (!cpu_clk_en_out && (!ext_irq_n_in || unit_req_in)
        |-> ##[1:4] cpu_clk_en_out) else $error("no wake from halt");
    cover property ($rose(mem_we_out));
    cover property ($fell(cpu_clk_en_out));
    cover property ($rose(cpu_clk_en_out) ##[1:4] mem_we_out);
endmodule
bind catl_core catl_core_assertions #(.VEC_PAGE(VEC_PAGE)) chk (.clk_in(clk_in), .rst_in(rst_in),
    .ext_irq_n_in(ext_irq_n_in), .unit_req_in(unit_req_in), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
    .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out));
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the execution core over axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "catl_consts.vh"
module testbench;
    localparam logic [3:0] PAGE = 4'h1;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic ext_irq_n = 1'b1, unit_req = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, mwe, mre, cen, pen;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] maddr;
    wire [7:0] mwd, mrd;
    int miscompares = 0, tests_run = 0, cycles = 0;
    logic [7:0] a = 8'h00, x = 8'h00, f = 8'he8, sp = 8'hff, m, op;
    logic [31:0] rv;
    logic [1:0] rs;
    logic [23:0] e;
    logic [15:0] pcv;
    logic [7:0] ops [0:11] = '{`CATL_OP_SUB_LIT, `CATL_OP_SUB_FULL, `CATL_OP_SUB_IX0,
        `CATL_OP_SUB_IX1, `CATL_OP_SUB_IX2, `CATL_OP_TAX, `CATL_OP_TXA, `CATL_OP_TST_A,
        `CATL_OP_TST_X, `CATL_OP_TST_PZ, `CATL_OP_TST_IX0, `CATL_OP_TST_IX1};
    logic [7:0] corner [0:3] = '{8'h00, 8'hff, 8'h80, 8'h01};
    catl_core #(.VEC_PAGE(PAGE)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .ext_irq_n_in(ext_irq_n),
        .unit_req_in(unit_req), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_we_out(mwe),
        .mem_re_out(mre), .mem_rdata_in(mrd), .cpu_clk_en_out(cen), .periph_clk_en_out(pen));
    catl_mem_model mem_model (.clk_in(clk_in), .mem_addr_in(maddr), .mem_wdata_in(mwd),
        .mem_we_in(mwe), .mem_re_in(mre), .mem_rdata_out(mrd));
    // 20 mhz clock
    initial forever #25 clk_in = ~clk_in;
    // hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            $display("ERROR %0t: timeout", $time);
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk_in);
            if (awready && !aw_ok)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_in); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] ad, output logic [31:0] d);
        @(posedge clk_in);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge clk_in);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_state(input logic [3:0] s);
        do axi_rd(`CATL_REG_STAT, rv); while (rv[3:0] !== s);
    endtask
    // expected accumulator, index and flags after one operation
    function automatic logic [23:0] exp_step(logic [7:0] o, ac, ix, fl, mo);
        logic [7:0] t;
        logic c;
        t = 8'h00;
        if (o == `CATL_OP_TAX)
            ix = ac;
        else if (o == `CATL_OP_TXA)
            ac = ix;
        else
        begin
            if (o[3:0] == 4'hd)
                t = (o == `CATL_OP_TST_A) ? ac : (o == `CATL_OP_TST_X) ? ix : mo;
            else
            begin
                c = ({1'b0, mo} + fl[`CATL_F_C]) > {1'b0, ac};
                t = ac - mo - fl[`CATL_F_C];
                ac = t;
                fl[`CATL_F_C] = c;
            end
            fl[`CATL_F_N] = t[7];
            fl[`CATL_F_Z] = (t == 8'h00);
        end
        return {ac, ix, fl};
    endfunction
    // stacked context, stack pointer, vector and mask after trap or service
    task automatic stk(input logic [15:0] pc, input logic [11:0] vec);
        chk(mem_model.mem[{8'h00, sp}], pc[7:0]);
        chk(mem_model.mem[{8'h00, sp - 8'h1}], pc[15:8]);
        chk(mem_model.mem[{8'h00, sp - 8'h2}], x);
        chk(mem_model.mem[{8'h00, sp - 8'h3}], a);
        chk(mem_model.mem[{8'h00, sp - 8'h4}], f);
        sp = sp - 8'h5;
        axi_rd(`CATL_REG_SP, rv);
        chk(rv, {24'h0, sp});
        axi_rd(`CATL_REG_PC, rv);
        chk(rv, {16'h0, mem_model.mem[{PAGE, vec}], mem_model.mem[{PAGE, vec + 12'h1}]});
        f = f | 8'h08;
        axi_rd(`CATL_REG_FLAG, rv);
        chk(rv, {24'h0, f});
    endtask
    initial
    begin
        rv = $urandom(98);
        for (int i = 0; i < 6; i++)
            mem_model.mem[{PAGE, 12'hff8 + 12'(i)}] = 8'h12 + 8'(i * 34);
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        axi_rd(`CATL_REG_FLAG, rv);
        chk(rv, {24'h0, f});
        axi_rd(`CATL_REG_SP, rv);
        chk(rv, {24'h0, sp});
        // every subtract, transfer and test opcode once, then random traffic
        for (int i = 0; i < 48; i++)
        begin
            op = (i < 12) ? ops[i] : ops[$urandom_range(11)];
            m = (i < 4) ? corner[i] : 8'($urandom);
            axi_wr(`CATL_REG_OPER, {24'h0, m}, rs);
            axi_wr(`CATL_REG_CTRL, {24'h0, op}, rs);
            wait_state(4'h1);
            e = exp_step(op, a, x, f, m);
            {a, x, f} = e;
            axi_rd(`CATL_REG_ACC, rv);
            chk(rv, {24'h0, a});
            axi_rd(`CATL_REG_IDX, rv);
            chk(rv, {24'h0, x});
            axi_rd(`CATL_REG_FLAG, rv);
            chk(rv, {24'h0, f});
            axi_rd(`CATL_REG_OPER, rv);
            chk(rv, {24'h0, m});
        end
        // trap with the mask already set
        axi_rd(`CATL_REG_PC, rv);
        pcv = rv[15:0] + 16'h1;
        axi_wr(`CATL_REG_CTRL, {24'h0, `CATL_OP_TRAP}, rs);
        wait_state(4'h1);
        stk(pcv, 12'hffc);
        // masked request must not be serviced
        unit_req <= 1'b1;
        repeat (20) @(posedge clk_in);
        axi_rd(`CATL_REG_SP, rv);
        chk(rv, {24'h0, sp});
        unit_req <= 1'b0;
        // halt, then wake by unit request and by the pin
        for (int k = 0; k < 2; k++)
        begin
            axi_wr(`CATL_REG_CTRL, {24'h0, `CATL_OP_HALT}, rs);
            wait_state(4'h4);
            chk(cen, 1'b0);
            chk(pen, 1'b1);
            f = f & 8'hf7;
            axi_rd(`CATL_REG_FLAG, rv);
            chk(rv, {24'h0, f});
            axi_rd(`CATL_REG_PC, rv);
            pcv = rv[15:0];
            if (k == 0)
                unit_req <= 1'b1;
            else
                ext_irq_n <= 1'b0;
            wait_state(4'h1);
            unit_req <= 1'b0;
            ext_irq_n <= 1'b1;
            chk(cen, 1'b1);
            stk(pcv, (k == 0) ? 12'hff8 : 12'hffa);
        end
        // refused write and unknown opcode
        axi_wr(`CATL_REG_ACC, 32'h55, rs);
        chk(rs, `CATL_RESP_SLVERR);
        axi_wr(`CATL_REG_CTRL, 32'h0, rs);
        axi_rd(`CATL_REG_STAT, rv);
        chk(rv[4:0], 5'h11);
        chk(rs, `CATL_RESP_OKAY);
        final_report();
    end
endmodule
`default_nettype wire
